/* spm_deglitch.sv */
// Deglitch filter: output follows input after a stable run of CYCLES clocks
`timescale 1ns/1ps
module spm_deglitch import spm_pkg::*; #(
  parameter int CYCLES = IGN_DEGLITCH_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic level_in,
  output logic level_out
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic level;
  } spm_dg_state_s;

  spm_dg_state_s st;
  spm_dg_state_s next_st;

  // Count while input differs; a single agreeing sample restarts the run
  always_comb begin
    next_st = st;
    if (level_in == st.level) begin
      next_st.cnt = '0;
    end else if (st.cnt == LAST) begin
      next_st.cnt = '0;
      next_st.level = level_in;
    end else begin
      next_st.cnt = st.cnt + CW'(1);
    end
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_out = st.level;

endmodule // spm_deglitch

/* spm_mcu_model.sv */
// Behavioural serial bus master standing in for the microcontroller
`timescale 1ns/1ps
module spm_mcu_model (
  output logic cs_n_out,
  output logic sclk_out,
  output logic mosi_out,
  input wire logic miso_in,
  output logic [15:0] rx_out
);
  event got;
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
    rx_out = 16'h0000;
  end
  // Sends nb bits of w; a short count makes a truncated frame
  task automatic xfer(input logic [15:0] w, input int nb);
    cs_n_out = 1'b0;
    #307;
    for (int i = 0; i < nb; i++) begin
      sclk_out = 1'b1;
      mosi_out = w[15-i];
      #160;
      sclk_out = 1'b0;
      #160;
      // Late sample: device output lags its pin by up to three clocks
      rx_out[15-i] = miso_in;
    end
    mosi_out = ~mosi_out; // Released line shows no stale bit
    #150;
    cs_n_out = 1'b1;
    ->got;
    #800;
  endtask
endmodule // spm_mcu_model

/* spm_pkg.sv */
// Constants, command codes and state types of the safety supply serial port
package spm_pkg;

  // Clock rate and ignition deglitch time
  localparam int CLK_FREQ_KHZ = 25000;
  localparam int IGN_DEGLITCH_US = 7500; // Least deglitch time, rounded up
  localparam int IGN_DEGLITCH_CYCLES =
    (IGN_DEGLITCH_US * CLK_FREQ_KHZ + 999) / 1000;

  // Frame layout
  localparam int FRAME_BITS = 16;
  localparam int CMD_BYTE_BITS = 8;
  localparam int FALL_CNT_W = 5;
  localparam logic [FALL_CNT_W-1:0] FALLS_FRAME = 5'h10;
  localparam logic [FALL_CNT_W-1:0] FALLS_CMD = 5'h08;
  localparam logic [FALL_CNT_W-1:0] FALLS_MAX = 5'h1F;

  // Status flag byte: fixed pattern in the upper nibble, bit 1 zero
  localparam logic [3:0] STAT_FIXED_HI = 4'hA;
  localparam int STAT_WR_BIT = 3;
  localparam int STAT_SDO_ERR_BIT = 2;
  localparam int STAT_INVALID_BIT = 0;

  // Register field positions and values after reset or wake
  localparam int CFG1_SEL_BIT = 7;
  localparam int CFG1_UNMASK_BIT = 6;
  localparam logic CFG1_UNMASK_RESET = 1'b0;
  localparam int CFG2_IO_OT_STBY_BIT = 7;
  localparam int CFG2_CAN_OT_EN_BIT = 6;
  localparam int CFG2_BAT_OV_MASK_BIT = 5;
  localparam int CFG2_POST_RUN_BIT = 4;
  localparam logic [7:0] CFG2_RESET = 8'hC0;
  localparam int WAKE_CAN_BIT = 1;
  localparam int WAKE_IGN_BIT = 0;

  // Command codes (values arbitrary, bits 7..1 of the first byte)
  localparam logic [6:0] CMD_RD_REV = 7'h0C;
  localparam logic [6:0] CMD_RD_ID = 7'h06;
  localparam logic [6:0] CMD_RD_WAKE = 7'h11;
  localparam logic [6:0] CMD_RD_CFG1 = 7'h23;
  localparam logic [6:0] CMD_WR_CFG1 = 7'h5C;
  localparam logic [6:0] CMD_RD_CFG2 = 7'h24;
  localparam logic [6:0] CMD_WR_CFG2 = 7'h6A;
  localparam logic [6:0] CMD_CAN_STANDBY_WRITE_CMD = 7'h3D;

  // Frame phase of the serial slave
  typedef enum logic [0:0] {PH_IDLE, PH_SHIFT} spm_phase_e;

  // Error and access flags reported in the next status byte
  typedef struct packed {
    logic wr;
    logic sdo_err;
    logic invalid;
  } spm_flags_s;

  // Whole state of the serial port and register block
  typedef struct packed {
    logic cs_m;
    logic cs_s;
    logic sck_m;
    logic sck_s;
    logic sck_d;
    logic sdi_m;
    logic sdi_s;
    logic rb_m;
    logic rb_s;
    logic sel_m;
    logic sel_s;
    logic can_m;
    logic can_s;
    logic can_d;
    logic ign_d;
    spm_phase_e phase;
    logic [FALL_CNT_W-1:0] falls;
    logic [FRAME_BITS-1:0] rx;
    logic [7:0] tx;
    logic sdo;
    logic oe;
    logic frame_sdo_err;
    logic frame_wr;
    spm_flags_s flags;
    logic sel_done;
    logic cfg1_sel;
    logic cfg1_unmask;
    logic [7:0] cfg2;
    logic can_latched;
    logic ign_status;
    logic core_ov_drive;
    logic core_uv_reset;
    logic io_ot_standby;
    logic io_ot_reg_off;
    logic can_ot_shutdown;
    logic bat_ov_reset;
    logic post_run_reset;
  } spm_state_s;

endpackage

/* spm_serial_port.sv */
// Serial slave port with status flags and wake/config registers
//
// Functional notes
// - Frames are sixteen bits, shifted most significant bit first.
// - Serial input is sampled on each falling serial clock edge.
// - Each new serial output bit is launched on a rising clock edge.
// - Chip select low frames a transfer; high holds reset, output off.
// - First byte: seven-bit command in bits 7..1, parity in bit 0.
// - First returned byte: bits 7..4 are 1010, bit 1 is zero.
// - Status reports previous frame: write, output error, invalid transfer.
// - Error flags of a truncated frame persist until a later valid read.
// - Read returns register contents in byte two, unused bits zero.
// - Register defaults reload on every ignition or CAN wake-up.
// - Revision register: major in upper nibble, minor in lower.
// - Wake status bit 1 latches CAN wake; cleared by standby or by the CAN standby write command.
// - Wake status bit 0 follows deglitched ignition, cleared on standby.
// - Config one bit 7: read-only select pin level latched at power-up.
// - Config one bit 6 resets 0; zero masks core supply faults.
// - Config two bit 7 resets 1; chooses standby or regulator off.
// - Config two bit 6 resets 1; zero disables CAN-supply shutdown.
// - Config two bit 5 resets 0; one masks battery overvoltage reset.
// - Config two bit 4 resets 0; crank during power latch forces reset.
`timescale 1ns/1ps
module spm_serial_port import spm_pkg::*; #(
  parameter logic ODD_PARITY = 1'b1,
  parameter int DEGLITCH_CYCLES = IGN_DEGLITCH_CYCLES,
  parameter logic [3:0] REV_MAJOR = 4'h1, // Arbitrary value
  parameter logic [3:0] REV_MINOR = 4'h0, // Arbitrary value
  parameter logic [7:0] IDENTITY = 8'h5A // Arbitrary value
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic chip_select_n_in,
  input wire logic serial_clk_in,
  input wire logic serial_data_in,
  input wire logic sdo_readback_in,
  input wire logic io_voltage_select_pin_in,
  input wire logic ignition_level_in,
  input wire logic can_wake_input_in,
  input wire logic global_standby_in,
  input wire logic ignition_power_latch_in,
  input wire logic core_supply_overvoltage_in,
  input wire logic core_supply_undervoltage_in,
  input wire logic io_regulator_overtemp_in,
  input wire logic can_supply_overtemp_flag_in,
  input wire logic battery_overvoltage_in,
  output logic serial_data_out,
  output logic serial_data_oe_out,
  output logic core_ov_to_enable_drive_out,
  output logic core_uv_to_reset_out,
  output logic io_overtemp_standby_out,
  output logic io_regulator_disable_out,
  output logic can_supply_shutdown_out,
  output logic battery_ov_reset_out,
  output logic post_run_reset_out
);

  spm_state_s st;
  spm_state_s next_st;
  logic ign_filtered;
  logic ign_m;
  logic ign_sync;

  // Ignition pin is synchronised here, then deglitched
  spm_deglitch #(
    .CYCLES(DEGLITCH_CYCLES)
  ) u_ign_filter (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .level_in(ign_sync),
    .level_out(ign_filtered)
  );

  // Two-stage synchroniser for the ignition pin
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ign_m <= 1'b0;
      ign_sync <= 1'b0;
    end else begin
      ign_m <= ignition_level_in;
      ign_sync <= ign_m;
    end
  end

  // Register contents as seen by a read command
  function automatic logic [7:0] read_data(input logic [6:0] cmd,
                                           input spm_state_s s);
    logic [7:0] d;
    d = 8'h00;
    case (cmd)
      CMD_RD_REV: d = {REV_MAJOR, REV_MINOR};
      CMD_RD_ID: d = IDENTITY;
      CMD_RD_WAKE: begin
        d[WAKE_CAN_BIT] = s.can_latched;
        d[WAKE_IGN_BIT] = s.ign_status;
      end
      CMD_RD_CFG1: begin
        d[CFG1_SEL_BIT] = s.cfg1_sel;
        d[CFG1_UNMASK_BIT] = s.cfg1_unmask;
      end
      CMD_RD_CFG2: d = s.cfg2;
      default: d = 8'h00;
    endcase
    return d;
  endfunction

  // Command classes
  function automatic logic is_read(input logic [6:0] cmd);
    return cmd == CMD_RD_REV || cmd == CMD_RD_ID || cmd == CMD_RD_WAKE ||
           cmd == CMD_RD_CFG1 || cmd == CMD_RD_CFG2;
  endfunction

  function automatic logic is_write(input logic [6:0] cmd);
    return cmd == CMD_WR_CFG1 || cmd == CMD_WR_CFG2 ||
           cmd == CMD_CAN_STANDBY_WRITE_CMD;
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    logic sck_fall;
    logic sck_rise;
    logic [6:0] cmd;
    logic [7:0] data;
    logic parity_ok;
    logic valid;
    logic [7:0] status;
    logic can_rise;
    logic wake;
    logic crank;
    sck_fall = 1'b0;
    sck_rise = 1'b0;
    cmd = 7'h00;
    data = 8'h00;
    parity_ok = 1'b0;
    valid = 1'b0;
    status = 8'h00;
    can_rise = 1'b0;
    wake = 1'b0;
    crank = 1'b0;
    next_st = st;

    // Pin synchronisers; first stages feed only the second
    next_st.cs_m = chip_select_n_in;
    next_st.cs_s = st.cs_m;
    next_st.sck_m = serial_clk_in;
    next_st.sck_s = st.sck_m;
    next_st.sck_d = st.sck_s;
    next_st.sdi_m = serial_data_in;
    next_st.sdi_s = st.sdi_m;
    next_st.rb_m = sdo_readback_in;
    next_st.rb_s = st.rb_m;
    next_st.sel_m = io_voltage_select_pin_in;
    next_st.sel_s = st.sel_m;
    next_st.can_m = can_wake_input_in;
    next_st.can_s = st.can_m;
    next_st.can_d = st.can_s;
    next_st.ign_d = ign_filtered;

    sck_fall = st.sck_d & ~st.sck_s;
    sck_rise = ~st.sck_d & st.sck_s;

    // Status byte built from the previous frame's flags
    status = {STAT_FIXED_HI, 4'h0};
    status[STAT_WR_BIT] = st.flags.wr;
    status[STAT_SDO_ERR_BIT] = st.flags.sdo_err;
    status[STAT_INVALID_BIT] = st.flags.invalid;

    cmd = st.rx[FRAME_BITS-1 -: 7];
    data = st.rx[7:0];
    parity_ok = (^cmd ^ ODD_PARITY) == st.rx[CMD_BYTE_BITS];

    // Serial frame engine
    case (st.phase)
      PH_IDLE: begin
        next_st.oe = 1'b0;
        next_st.sdo = 1'b0;
        next_st.falls = '0;
        next_st.frame_sdo_err = 1'b0;
        next_st.frame_wr = 1'b0;
        if (!st.cs_s) begin
          next_st.phase = PH_SHIFT;
          next_st.oe = 1'b1;
          next_st.sdo = status[7];
          next_st.tx = {status[6:0], 1'b0};
        end
      end
      PH_SHIFT: begin
        if (st.cs_s) begin
          // Frame end: check and commit
          valid = st.falls == FALLS_FRAME && parity_ok &&
                  (is_read(cmd) || is_write(cmd));
          next_st.phase = PH_IDLE;
          next_st.oe = 1'b0;
          next_st.sdo = 1'b0;
          // Write seen in the command phase counts even if the frame is cut
          next_st.flags.wr = st.frame_wr;
          if (valid && is_read(cmd)) begin
            next_st.flags.sdo_err = st.frame_sdo_err;
            next_st.flags.invalid = 1'b0;
          end else begin
            // Errors stick until a good read reports them
            next_st.flags.sdo_err = st.flags.sdo_err | st.frame_sdo_err;
            next_st.flags.invalid = st.flags.invalid | ~valid;
          end
          if (valid && cmd == CMD_WR_CFG1) begin
            next_st.cfg1_unmask = data[CFG1_UNMASK_BIT];
          end
          if (valid && cmd == CMD_WR_CFG2) begin
            next_st.cfg2 = data;
          end
        end else begin
          if (sck_fall) begin
            next_st.rx = {st.rx[FRAME_BITS-2:0], st.sdi_s};
            if (st.falls != FALLS_MAX) begin
              next_st.falls = st.falls + 5'h01;
            end
            if (st.rb_s != st.sdo) begin
              next_st.frame_sdo_err = 1'b1;
            end
            if (st.falls == FALLS_CMD - 5'h01) begin
              // Command byte complete: preload the answer byte
              // Seven command bits are in place, parity arrives now
              cmd = st.rx[6:0];
              next_st.frame_wr = is_write(cmd) &&
                                 (^cmd ^ ODD_PARITY) == st.sdi_s;
              if ((^cmd ^ ODD_PARITY) == st.sdi_s && is_read(cmd)) begin
                next_st.tx = read_data(cmd, st);
              end else begin
                next_st.tx = 8'h00;
              end
            end
          end
          if (sck_rise && st.falls != '0 && st.falls < FALLS_FRAME) begin
            next_st.sdo = st.tx[7];
            next_st.tx = {st.tx[6:0], 1'b0};
          end
        end
      end
      default: begin
        next_st.phase = PH_IDLE;
      end
    endcase

    // Select pin is caught once after power-up release only
    if (!st.sel_done) begin
      next_st.sel_done = 1'b1;
      next_st.cfg1_sel = st.sel_s;
    end

    // Wake events reload defaults; wake beats a same-cycle write
    can_rise = st.can_s & ~st.can_d;
    crank = ign_filtered & ~st.ign_d;
    wake = can_rise | crank;
    if (wake) begin
      next_st.cfg1_unmask = CFG1_UNMASK_RESET;
      next_st.cfg2 = CFG2_RESET;
    end

    // CAN wake latch: set wins over standby or command clear
    if (global_standby_in ||
        (st.phase == PH_SHIFT && st.cs_s && st.falls == FALLS_FRAME &&
         parity_ok && cmd == CMD_CAN_STANDBY_WRITE_CMD)) begin
      next_st.can_latched = 1'b0;
    end
    if (can_rise) begin
      next_st.can_latched = 1'b1;
    end
    next_st.ign_status = ign_filtered & ~global_standby_in;

    // Protection routing steered by configuration
    next_st.core_ov_drive = core_supply_overvoltage_in & st.cfg1_unmask;
    next_st.core_uv_reset = core_supply_undervoltage_in & st.cfg1_unmask;
    next_st.io_ot_standby =
      io_regulator_overtemp_in & st.cfg2[CFG2_IO_OT_STBY_BIT];
    next_st.io_ot_reg_off =
      io_regulator_overtemp_in & ~st.cfg2[CFG2_IO_OT_STBY_BIT];
    next_st.can_ot_shutdown =
      can_supply_overtemp_flag_in & st.cfg2[CFG2_CAN_OT_EN_BIT];
    next_st.bat_ov_reset =
      battery_overvoltage_in & ~st.cfg2[CFG2_BAT_OV_MASK_BIT];
    next_st.post_run_reset = crank & ignition_power_latch_in &
                             st.cfg2[CFG2_POST_RUN_BIT];
  end

  // State register; reset also forces defaults
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      st <= '0;
      st.cs_m <= 1'b1;
      st.cs_s <= 1'b1;
      // Strap sync keeps running so the first capture sees the pin
      st.sel_m <= next_st.sel_m;
      st.sel_s <= next_st.sel_s;
      st.phase <= PH_IDLE;
      st.cfg1_unmask <= CFG1_UNMASK_RESET;
      st.cfg2 <= CFG2_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign serial_data_out = st.sdo;
  assign serial_data_oe_out = st.oe;
  assign core_ov_to_enable_drive_out = st.core_ov_drive;
  assign core_uv_to_reset_out = st.core_uv_reset;
  assign io_overtemp_standby_out = st.io_ot_standby;
  assign io_regulator_disable_out = st.io_ot_reg_off;
  assign can_supply_shutdown_out = st.can_ot_shutdown;
  assign battery_ov_reset_out = st.bat_ov_reset;
  assign post_run_reset_out = st.post_run_reset;

endmodule // spm_serial_port

/* spm_serial_port_chk.sv */
// Checker of the serial port pins and protection outputs
`timescale 1ns/1ps
module spm_serial_port_chk (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic chip_select_n_in,
  input wire logic serial_clk_in,
  input wire logic core_supply_overvoltage_in,
  input wire logic core_supply_undervoltage_in,
  input wire logic io_regulator_overtemp_in,
  input wire logic can_supply_overtemp_flag_in,
  input wire logic battery_overvoltage_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe_out,
  input wire logic core_ov_to_enable_drive_out,
  input wire logic core_uv_to_reset_out,
  input wire logic io_overtemp_standby_out,
  input wire logic io_regulator_disable_out,
  input wire logic can_supply_shutdown_out,
  input wire logic battery_ov_reset_out,
  input wire logic post_run_reset_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // Five deselected samples outlast the two-flop sync and the register
  property p_oe_off;
    chip_select_n_in [*5] |-> !serial_data_oe_out;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("output driven while deselected");
  property p_oe_on;
    !chip_select_n_in [*5] |-> serial_data_oe_out;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("output not driven while selected");
  property p_first_bit;
    $rose(serial_data_oe_out) |-> serial_data_out;
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("status byte does not open with a one");
  // Output may only move shortly after a rising serial clock
  sequence s_low_sel;
    !serial_clk_in && !chip_select_n_in;
  endsequence
  property p_hold;
    s_low_sel [*7] |-> $stable(serial_data_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output bit moved during clock low phase");
  property p_core_ov;
    !core_supply_overvoltage_in |=> !core_ov_to_enable_drive_out;
  endproperty
  a_core_ov: assert property (p_core_ov)
    else $error("enable drive fault without overvoltage");
  property p_io_ot;
    io_regulator_overtemp_in
      |=> io_overtemp_standby_out != io_regulator_disable_out;
  endproperty
  a_io_ot: assert property (p_io_ot)
    else $error("overtemperature needs exactly one reaction");
  property p_can_ot;
    !can_supply_overtemp_flag_in |=> !can_supply_shutdown_out;
  endproperty
  a_can_ot: assert property (p_can_ot)
    else $error("supply shutdown without overtemperature");
  property p_bat_ov;
    !battery_overvoltage_in |=> !battery_ov_reset_out;
  endproperty
  a_bat_ov: assert property (p_bat_ov)
    else $error("reset request without battery overvoltage");
  property p_core_uv;
    !core_supply_undervoltage_in |=> !core_uv_to_reset_out;
  endproperty
  a_core_uv: assert property (p_core_uv)
    else $error("reset request without core undervoltage");
  // Post-run reset is a single-cycle request
  property p_post_run;
    post_run_reset_out |=> !post_run_reset_out;
  endproperty
  a_post_run: assert property (p_post_run)
    else $error("post-run reset held longer than one cycle");
  c_frame: cover property ($rose(serial_data_oe_out));
  c_standby: cover property (io_overtemp_standby_out);
  c_reg_off: cover property (io_regulator_disable_out);
  c_post_run: cover property (post_run_reset_out);
endmodule // spm_serial_port_chk

/* spm_serial_port_tb.sv */
// Self-checking bench of the serial port driven by the master model
`timescale 1ns/1ps
module spm_serial_port_tb;
  import spm_pkg::*;
  localparam int DG = 8;
  logic sys_clk_in, reset_in, io_voltage_select_pin_in, ignition_level_in;
  logic can_wake_input_in, global_standby_in, ignition_power_latch_in;
  logic core_supply_overvoltage_in, core_supply_undervoltage_in;
  logic io_regulator_overtemp_in, can_supply_overtemp_flag_in;
  logic battery_overvoltage_in, serial_data_out, serial_data_oe_out;
  logic core_ov_to_enable_drive_out, core_uv_to_reset_out;
  logic io_overtemp_standby_out, io_regulator_disable_out;
  logic can_supply_shutdown_out, battery_ov_reset_out, post_run_reset_out;
  wire logic chip_select_n_in, serial_clk_in, serial_data_in;
  wire logic sdo_readback_in;
  wire logic [15:0] rx;
  logic [31:0] rnd = 32'hD803643B;
  logic [31:0] q[$];
  logic [31:0] e;
  logic [7:0] d;
  logic wr_f, inv_f, sel;
  int fail_count, compares, pulses;
  // Released output line is pulled up; single slave, no spurious error
  assign sdo_readback_in = serial_data_oe_out ? serial_data_out : 1'b1;
  // Post-run reset pulses, counted away from the launching edge
  always @(negedge sys_clk_in)
    if (post_run_reset_out === 1'b1) pulses++;
  spm_serial_port #(.DEGLITCH_CYCLES(DG), .REV_MAJOR(4'h3),
    .REV_MINOR(4'h7), .IDENTITY(8'hC4)) // Arbitrary identity value
  u_spm_serial_port (.sys_clk_in, .reset_in, .chip_select_n_in,
    .serial_clk_in, .serial_data_in, .sdo_readback_in,
    .io_voltage_select_pin_in, .ignition_level_in, .can_wake_input_in,
    .global_standby_in, .ignition_power_latch_in,
    .core_supply_overvoltage_in, .core_supply_undervoltage_in,
    .io_regulator_overtemp_in, .can_supply_overtemp_flag_in,
    .battery_overvoltage_in, .serial_data_out, .serial_data_oe_out,
    .core_ov_to_enable_drive_out, .core_uv_to_reset_out,
    .io_overtemp_standby_out, .io_regulator_disable_out,
    .can_supply_shutdown_out, .battery_ov_reset_out, .post_run_reset_out);
  spm_mcu_model u_spm_mcu_model (.cs_n_out(chip_select_n_in),
    .sclk_out(serial_clk_in), .mosi_out(serial_data_in),
    .miso_in(sdo_readback_in), .rx_out(rx));
  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Random fault levels every cycle exercise the protection outputs
  always @(posedge sys_clk_in) begin
    #1;
    rnd = lfsr(rnd);
    {core_supply_overvoltage_in, core_supply_undervoltage_in,
      io_regulator_overtemp_in, can_supply_overtemp_flag_in,
      battery_overvoltage_in} = rnd[4:0];
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  // Queue the expected answer, send the frame, then track the flags
  task automatic frame(input logic [6:0] c, input logic [7:0] dt,
      input int nb, input logic bad, input logic rd, input logic [7:0] ex);
    logic [15:0] m;
    // A frame cut after eight or more bits still returns a whole status byte
    m = (nb < 8) ? 16'h0000 : ((rd && nb == 16) ? 16'hFFFF : 16'hFF00);
    q.push_back({m, 4'hA, wr_f, 2'b00, inv_f, bad ? 8'h00 : ex});
    tick(1);
    u_spm_mcu_model.xfer({c, ~^c ^ bad, dt}, nb);
    if (nb != 16 || bad)
      inv_f = 1'b1;
    else if (rd)
      inv_f = 1'b0;
    wr_f = nb >= 8 && !bad && !rd;
  endtask
  // Each finished frame is compared with the oldest note
  always @(u_spm_mcu_model.got) begin
    e = (q.size() > 0) ? q.pop_front() : 32'hFFFF0000;
    compares++;
    if (((rx ^ e[15:0]) & e[31:16]) !== 16'h0000) begin
      fail_count++;
      $display("FAIL %0t answer %h expected %h", $time, rx, e[15:0]);
    end
  end
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #2000000;
    fail_count++;
    $display("FAIL %0t run did not finish", $time);
    complete_run();
  end
  initial begin
    {wr_f, inv_f, fail_count, compares} = '0;
    sel = rnd[0];
    io_voltage_select_pin_in = sel;
    {ignition_level_in, can_wake_input_in, global_standby_in} = 3'b000;
    ignition_power_latch_in = 1'b0;
    reset_in = 1'b1;
    tick(12);
    reset_in = 1'b0;
    tick(4);
    frame(CMD_RD_CFG2, 8'h00, 16, 0, 1, CFG2_RESET);
    frame(CMD_RD_REV, rnd[15:8], 16, 0, 1, 8'h37);
    frame(CMD_RD_ID, 8'h00, 16, 0, 1, 8'hC4);
    d = rnd[23:16];
    frame(CMD_WR_CFG1, d, 16, 0, 0, 8'h00);
    frame(CMD_RD_CFG1, 8'h00, 16, 0, 1, {sel, d[6], 6'h00});
    d = rnd[15:8];
    frame(CMD_WR_CFG2, d, 16, 0, 0, 8'h00);
    frame(CMD_RD_CFG2, 8'h00, 16, 0, 1, d);
    frame(CMD_WR_CFG2, ~d, 15, 0, 0, 8'h00);
    frame(CMD_WR_CFG1, 8'h00, 16, 0, 0, 8'h00);
    frame(CMD_RD_CFG2, 8'h00, 16, 0, 1, d);
    frame(CMD_RD_REV, 8'h00, 16, 1, 1, 8'h00);
    frame(CMD_RD_ID, 8'h00, 16, 0, 1, 8'hC4);
    can_wake_input_in = 1'b1;
    tick(8);
    frame(CMD_RD_CFG2, 8'h00, 16, 0, 1, CFG2_RESET);
    frame(CMD_RD_CFG1, 8'h00, 16, 0, 1, {sel, 7'h00});
    frame(CMD_RD_WAKE, 8'h00, 16, 0, 1, 8'h02);
    can_wake_input_in = 1'b0;
    frame(CMD_CAN_STANDBY_WRITE_CMD, 8'h00, 16, 0, 0, 8'h00);
    frame(CMD_RD_WAKE, 8'h00, 16, 0, 1, 8'h00);
    frame(CMD_WR_CFG2, 8'h10, 16, 0, 0, 8'h00);
    ignition_power_latch_in = 1'b1;
    ignition_level_in = 1'b1;
    tick(DG + 8);
    frame(CMD_RD_WAKE, 8'h00, 16, 0, 1, 8'h01);
    frame(CMD_RD_CFG2, 8'h00, 16, 0, 1, CFG2_RESET);
    ignition_level_in = 1'b0;
    tick(DG + 8);
    frame(CMD_RD_WAKE, 8'h00, 16, 0, 1, 8'h00);
    can_wake_input_in = 1'b1;
    tick(4);
    can_wake_input_in = 1'b0;
    global_standby_in = 1'b1;
    tick(2);
    global_standby_in = 1'b0;
    frame(CMD_RD_WAKE, 8'h00, 16, 0, 1, 8'h00);
    tick(4);
    if (q.size() != 0) begin
      fail_count++;
      $display("FAIL %0t frames left unanswered", $time);
    end
    compares++;
    if (pulses != 1) begin
      fail_count++;
      $display("FAIL %0t post-run reset pulses %0d", $time, pulses);
    end
    complete_run();
  end
endmodule // spm_serial_port_tb
bind spm_serial_port spm_serial_port_chk u_spm_serial_port_chk (.*);
